// file: verilog/uls_consts.vh
/*
  constants for the line status block: bit positions, reset values, widths.
  assumes inclusion by bare name from the design files.
*/
`ifndef ULS_CONSTS_VH
`define ULS_CONSTS_VH
`define ULS_BIT_FIFO_ERR   7
`define ULS_BIT_TX_EMPTY   6
`define ULS_BIT_HOLD_EMPTY 5
`define ULS_BIT_BREAK      4
`define ULS_BIT_FRAMING    3
`define ULS_BIT_PARITY     2
`define ULS_BIT_OVERRUN    1
`define ULS_BIT_DATA_RDY   0
`define ULS_FLAG_BRK       2
`define ULS_FLAG_FE        1
`define ULS_FLAG_PE        0
`define ULS_FLAG_W         3
`define ULS_DATA_W         8
`define ULS_FIFO_DEPTH     128
`define ULS_FIFO_AW        7
`define ULS_FRAME_BITS     10
`define ULS_OVS            16
`define ULS_STAT_RESET     8'h60
`endif

// file: verilog/uls_rx_fifo.v
/*
  receive fifo: data byte plus break, framing and parity flags per entry,
  with a count of flagged entries for the error summary.
  assumes push and pop come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "uls_consts.vh"
module uls_rx_fifo #(
  parameter DEPTH = `ULS_FIFO_DEPTH,
  parameter AW    = `ULS_FIFO_AW
) (
  // clock and reset
  input  wire                                clk,
  input  wire                                rst,
  // fill side
  input  wire                                push,
  input  wire [`ULS_DATA_W+`ULS_FLAG_W-1:0]  push_word,
  // drain side
  input  wire                                pop,
  input  wire                                flush,
  output wire [`ULS_DATA_W+`ULS_FLAG_W-1:0]  top_word,
  output wire                                empty,
  output wire                                full,
  output wire                                any_err
);
  localparam W = `ULS_DATA_W + `ULS_FLAG_W;
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  reg [AW:0]   errcnt_r;
  wire         do_push;
  wire         do_pop;
  wire         in_err;
  wire         out_err;

  // flags are stored with each byte so top and summary derive from them
  assign do_push = push & ~full; // [RULE_15]
  assign do_pop  = pop & ~empty;
  assign empty   = (cnt_r == {(AW+1){1'b0}});
  assign full    = (cnt_r == DEPTH[AW:0]);
  assign top_word = mem[rp_r];
  assign in_err  = |push_word[`ULS_FLAG_W-1:0];
  assign out_err = |top_word[`ULS_FLAG_W-1:0];
  assign any_err = (errcnt_r != {(AW+1){1'b0}}); // [RULE_01] [RULE_02]

  always @(posedge clk) begin
    if (do_push)
      mem[wp_r] <= push_word;
  end

  // pointers, fill count and count of entries carrying any flag
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r     <= {AW{1'b0}};
      rp_r     <= {AW{1'b0}};
      cnt_r    <= {(AW+1){1'b0}};
      errcnt_r <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_r     <= {AW{1'b0}};
      rp_r     <= {AW{1'b0}};
      cnt_r    <= {(AW+1){1'b0}};
      errcnt_r <= {(AW+1){1'b0}};
    end else begin
      if (do_push)
        wp_r <= wp_r + 1'b1;
      if (do_pop)
        rp_r <= rp_r + 1'b1;
      cnt_r    <= cnt_r + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      errcnt_r <= errcnt_r + {{AW{1'b0}}, do_push & in_err}
                           - {{AW{1'b0}}, do_pop & out_err};
    end
  end
endmodule // uls_rx_fifo

// file: verilog/uls_line_status.v
/*
  line status logic of a single-channel uart: tx empty flags, break
  detection, receive error flags and the line status byte for the cpu.
  assumes receiver, transmitter and bus decode on the same clock; the rx
  pin is asynchronous and is synchronised here.
*/
// Contract
// [RULE_01] summary bit set when fifo holds flagged byte
// [RULE_02] summary clears when no flagged bytes remain
// [RULE_03] summary, break, framing bits zero after reset
// [RULE_04] non-fifo: tx empty when holding, shift empty
// [RULE_05] tx empty low while either holds character
// [RULE_06] fifo mode: tx empty when fifo, shift empty
// [RULE_07] non-fifo: holding empty set on transfer to shift
// [RULE_08] holding empty cleared with cpu holding write
// [RULE_09] fifo mode: holding empty follows fifo empty
// [RULE_10] holding empty plus enable raises interrupt
// [RULE_11] break set after rx low one frame
// [RULE_12] one break character per break condition
// [RULE_13] framing flag refers to top fifo character
// [RULE_14] parity flag refers to top fifo character
// [RULE_15] flags stored with every receive fifo entry
// [RULE_16] line status read-only, writes ignored
`timescale 1ns/1ps
`include "uls_consts.vh"
module uls_line_status #(
  parameter FRAME_BITS = `ULS_FRAME_BITS,
  parameter OVS        = `ULS_OVS
) (
  // clock and reset
  input  wire                   clk,
  input  wire                   rst,
  // configuration
  input  wire                   fifo_en,
  input  wire                   thre_int_en,
  input  wire                   baud_tick,
  // serial receive pin
  input  wire                   rx_pin,
  // receiver character strobe
  input  wire                   rx_char_valid,
  input  wire [`ULS_DATA_W-1:0] rx_char_data,
  input  wire                   rx_char_fe,
  input  wire                   rx_char_pe,
  input  wire                   rx_overrun,
  // cpu access
  input  wire                   lsr_rd,
  input  wire                   lsr_wr,
  input  wire                   rbr_rd,
  input  wire                   thr_wr,
  // transmitter side
  input  wire                   tx_load,
  input  wire                   tx_shift_busy,
  input  wire                   tx_fifo_empty,
  // outputs
  output reg  [7:0]             line_status,
  output reg  [`ULS_DATA_W-1:0] rx_data,
  output reg                    thre_irq
);
  localparam BRK_W = 16;
  localparam integer     BRK_PROD  = FRAME_BITS * OVS;
  localparam [BRK_W-1:0] BRK_TICKS = BRK_PROD[BRK_W-1:0]; // frame time must fit the counter
  localparam FW = `ULS_DATA_W + `ULS_FLAG_W;

  reg              rx_s1_r;
  reg              rx_s2_r;
  reg [BRK_W-1:0]  low_cnt_r;
  reg              in_break_r;
  reg              brk_push_r;
  reg              hold_full_r;
  reg              hold_empty_r;
  reg              tx_empty_r;
  reg              brk_hold_r;
  reg              fe_hold_r;
  reg              pe_hold_r;
  reg              oe_r;
  reg [FW-1:0]     nf_word_r;
  reg              nf_valid_r;
  wire             push;
  wire [FW-1:0]    push_word;
  wire [FW-1:0]    top_word;
  wire             f_empty;
  wire             f_full;
  wire             f_any_err;
  wire [FW-1:0]    cur_word;
  wire             have_data;
  reg  [7:0]       lsr_nxt;

  // two-flop synchroniser on the asynchronous rx pin
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
    end
  end

  // break: count oversample ticks while low; one push per break
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_r  <= {BRK_W{1'b0}};
      in_break_r <= 1'b0;
      brk_push_r <= 1'b0;
    end else begin
      brk_push_r <= 1'b0;
      if (rx_s2_r) begin
        low_cnt_r  <= {BRK_W{1'b0}};
        in_break_r <= 1'b0;
      end else if (baud_tick && !in_break_r) begin
        if (low_cnt_r == BRK_TICKS - 1'b1) begin
          in_break_r <= 1'b1; // [RULE_11]
          brk_push_r <= 1'b1; // [RULE_12]
        end else begin
          low_cnt_r <= low_cnt_r + 1'b1;
        end
      end
    end
  end

  // a break entry is a zero byte with the break flag; rx strobe wins
  assign push = rx_char_valid | brk_push_r;
  assign push_word = rx_char_valid ?
    {rx_char_data, 1'b0, rx_char_fe, rx_char_pe} :
    {{`ULS_DATA_W{1'b0}}, 3'h4};

  uls_rx_fifo u_fifo (
    .clk       (clk),
    .rst       (rst),
    .push      (push & fifo_en),
    .push_word (push_word),
    .pop       (rbr_rd & fifo_en),
    .flush     (~fifo_en),
    .top_word  (top_word),
    .empty     (f_empty),
    .full      (f_full),
    .any_err   (f_any_err)
  );

  // non-fifo mode keeps a single holding word
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      nf_word_r  <= {FW{1'b0}};
      nf_valid_r <= 1'b0;
    end else if (push && !fifo_en) begin
      nf_word_r  <= push_word;
      nf_valid_r <= 1'b1;
    end else if (rbr_rd || fifo_en) begin
      nf_valid_r <= 1'b0;
    end
  end

  assign cur_word  = fifo_en ? top_word : nf_word_r;
  assign have_data = fifo_en ? ~f_empty : nf_valid_r;

  // top-of-fifo flags shown while data present
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      brk_hold_r <= 1'b0; // [RULE_03]
      fe_hold_r  <= 1'b0;
      pe_hold_r  <= 1'b0;
      oe_r       <= 1'b0;
    end else begin
      brk_hold_r <= have_data & cur_word[`ULS_FLAG_BRK];
      fe_hold_r  <= have_data & cur_word[`ULS_FLAG_FE]; // [RULE_13]
      pe_hold_r  <= have_data & cur_word[`ULS_FLAG_PE]; // [RULE_14]
      // overrun: set wins over the read clear
      if (rx_overrun || (push && fifo_en && f_full))
        oe_r <= 1'b1;
      else if (lsr_rd)
        oe_r <= 1'b0;
    end
  end

  // non-fifo holding register occupancy and holding-empty flag
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_full_r  <= 1'b0;
      hold_empty_r <= 1'b1;
      tx_empty_r   <= 1'b1;
    end else begin
      if (thr_wr)
        hold_full_r <= 1'b1;
      else if (tx_load)
        hold_full_r <= 1'b0;
      if (fifo_en)
        hold_empty_r <= tx_fifo_empty & ~thr_wr; // [RULE_09]
      else if (thr_wr)
        hold_empty_r <= 1'b0; // [RULE_08]
      else if (tx_load)
        hold_empty_r <= 1'b1; // [RULE_07]
      if (fifo_en)
        tx_empty_r <= tx_fifo_empty & ~thr_wr & ~tx_shift_busy; // [RULE_06]
      else
        tx_empty_r <= ~hold_full_r & ~thr_wr & ~tx_shift_busy; // [RULE_04] [RULE_05]
    end
  end

  // assemble status byte; lsr_wr has no effect
  always @* begin
    lsr_nxt = 8'h00;
    lsr_nxt[`ULS_BIT_FIFO_ERR]   = fifo_en & f_any_err; // [RULE_01] [RULE_02]
    lsr_nxt[`ULS_BIT_TX_EMPTY]   = tx_empty_r;
    lsr_nxt[`ULS_BIT_HOLD_EMPTY] = hold_empty_r;
    lsr_nxt[`ULS_BIT_BREAK]      = brk_hold_r;
    lsr_nxt[`ULS_BIT_FRAMING]    = fe_hold_r;
    lsr_nxt[`ULS_BIT_PARITY]     = pe_hold_r;
    lsr_nxt[`ULS_BIT_OVERRUN]    = oe_r;
    lsr_nxt[`ULS_BIT_DATA_RDY]   = have_data;
  end

  // registered outputs; status ignores cpu writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      line_status <= `ULS_STAT_RESET; // [RULE_03]
      rx_data     <= {`ULS_DATA_W{1'b0}};
      thre_irq    <= 1'b0;
    end else begin
      line_status <= lsr_nxt; // [RULE_16]
      rx_data     <= cur_word[FW-1:`ULS_FLAG_W];
      thre_irq    <= lsr_nxt[`ULS_BIT_HOLD_EMPTY] & thre_int_en; // [RULE_10]
    end
  end
endmodule // uls_line_status

// file: testbench/uls_tx_model.sv
/*
  transmitter-side model: holding or fifo occupancy, shift time, baud ticks.
  assumes the same clock and reset as the line status block.
*/
`timescale 1ns/1ps
module uls_tx_model (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // cpu write into holding register or fifo
  input  wire thr_wr,
  // transmitter state
  output reg  tx_load,
  output wire tx_shift_busy,
  output wire tx_fifo_empty,
  output reg  baud_tick
);
  reg [7:0] pend_r;
  reg [3:0] shift_r;
  assign tx_fifo_empty = (pend_r == 8'h00);
  assign tx_shift_busy = (shift_r != 4'h0);
  // no load on a write edge, so each flag change has a single cause
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r    <= 8'h00;
      shift_r   <= 4'h0;
      tx_load   <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= ~baud_tick;
      tx_load   <= !tx_fifo_empty && !tx_shift_busy && !tx_load && !thr_wr;
      pend_r    <= pend_r + {7'h00, thr_wr} - {7'h00, tx_load};
      if (tx_load)
        shift_r <= 4'h8;
      else if (tx_shift_busy)
        shift_r <= shift_r - 4'h1;
    end
  end
endmodule // uls_tx_model

// file: testbench/uls_line_status_assertions.sv
/*
  port checker for the line status block.
  assumes one clock; bound to every instance.
*/
`timescale 1ns/1ps
module uls_chk #(
  parameter FRAME_BITS = 10,
  parameter OVS        = 16
) (
  // clock and reset
  input wire       clk,
  input wire       rst,
  // inputs
  input wire       fifo_en,
  input wire       thre_int_en,
  input wire       baud_tick,
  input wire       rx_pin,
  input wire       thr_wr,
  input wire       tx_load,
  input wire       tx_shift_busy,
  input wire       tx_fifo_empty,
  // outputs
  input wire [7:0] line_status,
  input wire       thre_irq
);
  // ticks of low line; slack of 2 covers the pin synchroniser
  reg [15:0] low_r;
  always @(posedge clk or posedge rst) begin
    if (rst)
      low_r <= 16'h0000;
    else if (rx_pin)
      low_r <= 16'h0000;
    else if (baud_tick && low_r != 16'hFFFF)
      low_r <= low_r + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rst_val_a: assert property (@(posedge clk) disable iff (1'b0) rst |-> line_status == 8'h60)
    else $error("status not at reset value");
  // tx flags trail their cause by two edges: flag register, then output register
  hold_clr_a: assert property (!fifo_en && thr_wr |-> ##2 !line_status[5])
    else $error("holding empty kept after write");
  hold_set_a: assert property (!fifo_en && tx_load && !thr_wr |-> ##2 line_status[5])
    else $error("holding empty not set on load");
  txe_low_a: assert property (tx_shift_busy |=> !line_status[6])
    else $error("tx empty set while shifting");
  txe_set_a: assert property ((!fifo_en)[*2] ##0 (tx_fifo_empty && !tx_shift_busy && !thr_wr)
    |-> ##2 line_status[6])
    else $error("tx empty missing");
  fifo_txe_a: assert property (fifo_en[*2] ##0 (tx_fifo_empty && !tx_shift_busy && !thr_wr)
    |-> ##2 line_status[6])
    else $error("fifo tx empty missing");
  fifo_hold_a: assert property (fifo_en[*2] ##0 !tx_fifo_empty |=> !line_status[5])
    else $error("holding empty with data queued");
  irq_req_a: assert property ((line_status[5] && thre_int_en)[*2] |-> thre_irq)
    else $error("interrupt request missing");
  err_sum_a: assert property (fifo_en && ($rose(line_status[3]) || $rose(line_status[4]))
    |-> line_status[7])
    else $error("error summary missing");
  brk_set_a: assert property (low_r == FRAME_BITS * OVS + 2 |-> ##[0:8] line_status[4])
    else $error("break not flagged");
  cover property (fifo_en && thr_wr);
  cover property ($rose(line_status[4]));
  cover property ($fell(line_status[7]));
endmodule // uls_chk
bind uls_line_status uls_chk #(.FRAME_BITS(FRAME_BITS), .OVS(OVS)) i_uls_chk (
  .clk(clk), .rst(rst), .fifo_en(fifo_en), .thre_int_en(thre_int_en),
  .baud_tick(baud_tick), .rx_pin(rx_pin), .thr_wr(thr_wr), .tx_load(tx_load),
  .tx_shift_busy(tx_shift_busy), .tx_fifo_empty(tx_fifo_empty),
  .line_status(line_status), .thre_irq(thre_irq));

// file: testbench/uls_line_status_tb_top.sv
/*
  bench for the line status block with the transmitter model.
  assumes short break count parameters: 2 bits of 2 ticks.
*/
`timescale 1ns/1ps
module uls_line_status_tb_top;
  reg        clk = 1'b0;
  reg        rst = 1'b0; // raised at time zero so the async reset edge is seen
  reg        fifo_en = 1'b0;
  reg        thre_int_en = 1'b0;
  reg        rx_pin = 1'b1;
  reg        rx_char_valid = 1'b0;
  reg  [7:0] rx_char_data = 8'h00;
  reg        rx_char_fe = 1'b0;
  reg        rx_char_pe = 1'b0;
  reg  [3:0] stb = 4'h0;
  wire       baud_tick, tx_load, tx_shift_busy, tx_fifo_empty, thre_irq;
  wire [7:0] line_status, rx_data;
  integer    errors = 0;
  integer    checked = 0;
  integer    cyc = 0;
  always #20 clk = ~clk;
  // strobes: 0 status read, 1 status write, 2 data pop, 3 holding write
  uls_line_status #(.FRAME_BITS(2), .OVS(2)) i_uls_line_status (
    .clk(clk), .rst(rst), .fifo_en(fifo_en), .thre_int_en(thre_int_en),
    .baud_tick(baud_tick), .rx_pin(rx_pin), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_char_fe(rx_char_fe), .rx_char_pe(rx_char_pe),
    .rx_overrun(1'b0), .lsr_rd(stb[0]), .lsr_wr(stb[1]), .rbr_rd(stb[2]),
    .thr_wr(stb[3]), .tx_load(tx_load), .tx_shift_busy(tx_shift_busy),
    .tx_fifo_empty(tx_fifo_empty), .line_status(line_status), .rx_data(rx_data),
    .thre_irq(thre_irq));
  uls_tx_model i_uls_tx_model (.clk(clk), .rst(rst), .thr_wr(stb[3]), .tx_load(tx_load),
    .tx_shift_busy(tx_shift_busy), .tx_fifo_empty(tx_fifo_empty), .baud_tick(baud_tick));
  task automatic step(input integer n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  // gap cycle after each strobe keeps one assignment per time step
  task automatic strobe(input [3:0] m, input integer n);
    stb = m;
    step(n);
    stb = 4'h0;
    step(1);
  endtask
  task automatic chk(input string name, input [7:0] seen, input [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_bit(input integer b);
    integer k;
    k = 0;
    while (line_status[b] !== 1'b1 && k < 100) begin
      step(1);
      k = k + 1;
    end
  endtask
  task automatic rxc(input [7:0] d, input fe, input pe);
    rx_char_data = d;
    rx_char_fe = fe;
    rx_char_pe = pe;
    rx_char_valid = 1'b1;
    step(1);
  endtask
  task automatic t_reset;
    rst = 1'b1;
    step(12);
    chk("in_reset", line_status, 8'h60);
    rst = 1'b0;
    strobe(4'h1, 1);
    chk("idle", line_status, 8'h60);
  endtask
  task automatic t_tx;
    thre_int_en = 1'b1;
    strobe(4'h8, 1);
    chk("wr", line_status[6:5], 8'h00);
    wait_bit(5);
    chk("loaded", line_status[6:5], 8'h01);
    step(1);
    chk("irq_on", thre_irq, 8'h01);
    thre_int_en = 1'b0;
    step(2);
    chk("irq_off", thre_irq, 8'h00);
    wait_bit(6);
    chk("tx_done", line_status[6:5], 8'h03);
  endtask
  task automatic t_fifo_tx;
    fifo_en = 1'b1;
    step(2);
    strobe(4'h8, 2);
    chk("fifo_wr", line_status[6:5], 8'h00);
    wait_bit(6);
    chk("fifo_done", line_status[6:5], 8'h03);
  endtask
  task automatic t_rx_err;
    rxc(8'hA5, 1'b1, 1'b0);
    rxc(8'h3C, 1'b0, 1'b1);
    rxc(8'h5A, 1'b0, 1'b0);
    rx_char_valid = 1'b0;
    step(3);
    chk("fe_top", line_status, 8'hE9);
    chk("fe_data", rx_data, 8'hA5);
    strobe(4'h2, 1);
    chk("wr_ignored", line_status, 8'hE9);
    strobe(4'h4, 1);
    step(1);
    chk("pe_top", line_status, 8'hE5);
    strobe(4'h4, 1);
    step(1);
    chk("clean", line_status, 8'h61);
    chk("clean_data", rx_data, 8'h5A);
    strobe(4'h4, 1);
    step(1);
    chk("drained", line_status, 8'h60);
  endtask
  task automatic t_break;
    rx_pin = 1'b0;
    step(40);
    rx_pin = 1'b1;
    step(4);
    chk("brk", line_status, 8'hF1);
    chk("brk_data", rx_data, 8'h00);
    strobe(4'h4, 1);
    step(1);
    chk("brk_once", line_status, 8'h60);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    t_reset;
    t_tx;
    t_fifo_tx;
    t_rx_err;
    t_break;
    wrap_up;
  end
  // hang guard well beyond the hundred or so cycles needed
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      wrap_up;
    end
  end
endmodule // uls_line_status_tb_top
